// [design/link_cfg.svh]
// Notes on behaviour
// - a terminal assigned code 24 switches command source between link and terminals
// - with no terminal assigned link-enable, communications stays valid
// - positive logic: input off is invalid, on (shorted to common) is valid
// - link command and operation data clear at power-up; host rewrites them
// - link data writes accepted while invalid, stored, applied once valid; the code queues eight, applying them once freq or run is from link
// - negative logic (code 1048) inverts the link-enable input sense
// - override forces link valid; frequency and run sources chosen separately
// - override is volatile and resets to zero
// - two independent ten-parameter serial setting sets, one per port; the code holds eight fields per port
// - station address range by protocol: rtu 1-247/0, loader 1-255, general 1-31/99
// - out-of-range station address suppresses all responses
// - address, parity, framing, transmission, disconnection faults are link errors
// - errors act only when running with run and frequency both from link
// - action 0: show port error, immediate alarm stop
// - action 1: run for timer period, then show error and alarm stop
// - action 2: run for timer; recovery keeps running, else error and stop
// - action 3: keep running despite errors
// - error timer 0.0 to 60.0 s in tenths
// - baud codes 0-4 give 2400, 4800, 9600, 19200, 38400 bit/s
// - length code 0 is 8 bits, 1 is 7 bits
// - parity 0 none, 1 even, 2 odd, 3 none; rtu stop bits 2 for 0, else 1
// - loader protocol forces 8 bits, even parity
// - outside rtu, stop code 0 gives two stop bits, 1 gives one
`ifndef LINK_CFG_SVH
`define LINK_CFG_SVH
`define LE_FUNC_CODE       11'h018
`define LE_FUNC_CODE_NEG   11'h418
`define TIMER_MAX_TENTHS   10'h258
`define TENTH_SEC_NS       100000000
`define CLK_PERIOD_NS      25
`define CLK_HZ             40000000
`define RTU_ADDR_MAX       8'hF7
`define LOADER_ADDR_MAX    8'hFF
`define GEN_ADDR_MAX       8'h1F
`define GEN_BROADCAST      8'h63
`define RTU_BROADCAST      8'h00
`define BAUD_2400          2400
`define BAUD_4800          4800
`define BAUD_9600          9600
`define BAUD_19200         19200
`define BAUD_38400         38400
`define OVERRIDE_RESET     2'h0
`define NUM_TERMINALS      7
`endif

// [design/link_pkg.sv]
package link_pkg;
   typedef enum logic [1:0] {PROTO_RTU, PROTO_LOADER, PROTO_GENERAL, PROTO_OTHER} proto_t;
   typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} parity_t;
   typedef struct packed {
      logic [7:0] station_address;
      logic [1:0] error_action;
      logic [9:0] error_timer;
      logic [2:0] baud_code;
      logic       char_length;
      logic [1:0] parity_code;
      logic       stop_bits;
      proto_t     protocol;
   } port_cfg_t;
   typedef struct packed {
      logic [15:0] baud_div;
      logic [3:0]  data_bits;
      parity_t     parity;
      logic [1:0]  stop_count;
   } frame_cfg_t;
   typedef struct packed {
      logic [15:0] freq;
      logic [15:0] freq_alt;
      logic [15:0] run_word;
   } link_cmd_t;
   typedef struct packed {
      logic address;
      logic parity;
      logic framing;
      logic transmission;
      logic disconnect;
   } link_err_t;
endpackage

// [design/cmd_fifo.sv]
`timescale 1ns/1ps
module cmd_fifo #(
   parameter int WIDTH = 48,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic             ce,
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;

   assign in_ready  = (count_reg != (AW+1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign push      = ce && in_valid && in_ready;
   assign pop       = ce && out_valid && out_ready;
   assign out_data  = mem[rd_ptr_reg];

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         if (push && !pop)
         begin
            count_reg <= count_reg + 1'b1;
         end
         else if (pop && !push)
         begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule

// [design/link_ctrl.sv]
`timescale 1ns/1ps
`include "link_cfg.svh"
module link_ctrl #(
   parameter int NUM_TERM    = `NUM_TERMINALS,
   parameter int FIFO_DEPTH  = 8,
   parameter int TENTH_TICKS = `TENTH_SEC_NS / `CLK_PERIOD_NS,
   parameter int CLK_HZ      = `CLK_HZ
) (
   input  wire logic                        clk,
   input  wire logic                        srst,
   input  wire logic                        ce,
   input  wire logic [NUM_TERM-1:0]         terminal_level,
   input  wire logic [NUM_TERM*11-1:0]      input_terminal_function_codes,
   input  wire logic [3:0]                  link_source_select,
   input  wire logic [1:0]                  support_link_override_wr_data,
   input  wire logic                        support_link_override_wr,
   input  wire logic                        cmd_valid,
   output      logic                        cmd_ready,
   input  wire link_pkg::link_cmd_t         cmd_data,
   input  wire link_pkg::port_cfg_t         port1_cfg,
   input  wire link_pkg::port_cfg_t         port2_cfg,
   input  wire logic [1:0]                  char_boundary,
   input  wire link_pkg::link_err_t         port1_err,
   input  wire link_pkg::link_err_t         port2_err,
   input  wire logic [1:0]                  link_recovered,
   input  wire logic                        running,
   output      logic                        link_valid,
   output      logic [1:0]                  support_link_override,
   output      logic                        freq_from_link,
   output      logic                        run_from_link,
   output      link_pkg::link_cmd_t         applied_cmd,
   output      link_pkg::frame_cfg_t        port1_frame,
   output      link_pkg::frame_cfg_t        port2_frame,
   output      logic [1:0]                  respond_enable,
   output      logic [1:0]                  error_display,
   output      logic                        alarm_stop
);
   localparam int TW = $clog2(TENTH_TICKS + 1);

   typedef enum logic [1:0] {ERR_IDLE, ERR_HOLD, ERR_TRIP} err_state_t;

   logic [NUM_TERM-1:0]  le_assigned;
   logic [NUM_TERM-1:0]  le_on;
   logic                 le_present;
   logic                 le_level;
   logic                 cmd_pop;
   link_pkg::link_cmd_t  fifo_out;
   logic                 fifo_valid;
   link_pkg::link_cmd_t  applied_reg;
   logic [1:0]           override_reg;
   logic                 freq_src1;
   logic                 freq_src2;
   logic                 run_src1;
   logic                 run_src2;
   logic                 freq_link;
   logic                 run_link;
   logic                 err_armed;
   link_pkg::port_cfg_t  cfg_arr [2];
   link_pkg::link_err_t  err_arr [2];
   link_pkg::frame_cfg_t frame_reg [2];
   err_state_t           err_state_reg [2];
   logic [9:0]           tenth_cnt_reg [2];
   logic [TW-1:0]        tick_cnt_reg [2];
   logic [1:0]           trip;
   logic [1:0]           display_reg;
   logic                 alarm_reg;

   // per-terminal link-enable decode with optional inversion
   genvar gi;
   generate
      for (gi = 0; gi < NUM_TERM; gi++)
      begin : g_term
         logic [10:0] code;
         assign code           = input_terminal_function_codes[gi*11 +: 11];
         assign le_assigned[gi] = (code == `LE_FUNC_CODE) || (code == `LE_FUNC_CODE_NEG);
         assign le_on[gi]      = le_assigned[gi] && (terminal_level[gi] ^ (code == `LE_FUNC_CODE_NEG));
      end
   endgenerate

   assign le_present = |le_assigned;
   assign le_level   = le_present ? |le_on : 1'b1;

   // override is volatile, reset clears it
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         override_reg <= `OVERRIDE_RESET;
      end
      else if (ce && support_link_override_wr)
      begin
         override_reg <= support_link_override_wr_data;
      end
   end

   assign freq_src1 = (link_source_select == 4'h1) || (link_source_select == 4'h3) || (link_source_select == 4'h7);
   assign freq_src2 = (link_source_select == 4'h4) || (link_source_select == 4'h5) || (link_source_select == 4'h8);
   assign run_src1  = (link_source_select == 4'h2) || (link_source_select == 4'h3) || (link_source_select == 4'h5);
   assign run_src2  = (link_source_select >= 4'h6) && (link_source_select <= 4'h8);
   assign freq_link = (le_level && (freq_src1 || freq_src2)) || override_reg[0];
   assign run_link  = (le_level && (run_src1 || run_src2)) || override_reg[1];

   // commands queue up while neither freq nor run is from link and drain once either is
   assign cmd_pop = fifo_valid && (freq_link || run_link);

   cmd_fifo #(
      .WIDTH ($bits(link_pkg::link_cmd_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .srst      (srst),
      .ce        (ce),
      .in_valid  (cmd_valid),
      .in_ready  (cmd_ready),
      .in_data   (cmd_data),
      .out_valid (fifo_valid),
      .out_ready (cmd_pop),
      .out_data  (fifo_out)
   );

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         applied_reg <= '0;
      end
      else if (ce && cmd_pop)
      begin
         applied_reg <= fifo_out;
      end
   end

   assign cfg_arr[0] = port1_cfg;
   assign cfg_arr[1] = port2_cfg;
   assign err_arr[0] = port1_err;
   assign err_arr[1] = port2_err;
   assign err_armed  = running && freq_link && run_link;

   function automatic logic addr_ok(input link_pkg::port_cfg_t c);
      case (c.protocol)
         link_pkg::PROTO_RTU:     addr_ok = (c.station_address <= `RTU_ADDR_MAX);
         link_pkg::PROTO_LOADER:  addr_ok = (c.station_address != 8'h00) && (c.station_address <= `LOADER_ADDR_MAX);
         link_pkg::PROTO_GENERAL: addr_ok = (c.station_address == `GEN_BROADCAST) ||
                                            ((c.station_address != 8'h00) && (c.station_address <= `GEN_ADDR_MAX));
         default:                 addr_ok = 1'b0;
      endcase
   endfunction

   function automatic link_pkg::frame_cfg_t decode_frame(input link_pkg::port_cfg_t c);
      link_pkg::frame_cfg_t f;
      int unsigned rate;
      f = '0;
      case (c.baud_code)
         3'h0:    rate = `BAUD_2400;
         3'h1:    rate = `BAUD_4800;
         3'h2:    rate = `BAUD_9600;
         3'h3:    rate = `BAUD_19200;
         default: rate = `BAUD_38400;
      endcase
      f.baud_div  = 16'(CLK_HZ / rate);
      f.data_bits = c.char_length ? 4'h7 : 4'h8;
      case (c.parity_code)
         2'h1:    f.parity = link_pkg::PAR_EVEN;
         2'h2:    f.parity = link_pkg::PAR_ODD;
         default: f.parity = link_pkg::PAR_NONE;
      endcase
      if (c.protocol == link_pkg::PROTO_RTU)
      begin
         f.stop_count = (c.parity_code == 2'h0) ? 2'h2 : 2'h1;
      end
      else
      begin
         f.stop_count = c.stop_bits ? 2'h1 : 2'h2;
      end
      if (c.protocol == link_pkg::PROTO_LOADER)
      begin
         f.data_bits = 4'h8;
         f.parity    = link_pkg::PAR_EVEN;
      end
      decode_frame = f;
   endfunction

   genvar pi;
   generate
      for (pi = 0; pi < 2; pi++)
      begin : g_port
         logic any_err;
         assign any_err = |err_arr[pi];
         assign respond_enable[pi] = addr_ok(cfg_arr[pi]);

         always_ff @(posedge clk)
         begin
            if (srst)
            begin
               frame_reg[pi] <= decode_frame('0);
            end
            else if (ce && char_boundary[pi])
            begin
               frame_reg[pi] <= decode_frame(cfg_arr[pi]);
            end
         end

         always_ff @(posedge clk)
         begin
            if (srst)
            begin
               err_state_reg[pi] <= ERR_IDLE;
               tenth_cnt_reg[pi] <= '0;
               tick_cnt_reg[pi]  <= '0;
            end
            else if (ce)
            begin
               case (err_state_reg[pi])
                  ERR_IDLE:
                  begin
                     tenth_cnt_reg[pi] <= '0;
                     tick_cnt_reg[pi]  <= '0;
                     if (any_err && err_armed)
                     begin
                        case (cfg_arr[pi].error_action)
                           2'h0:    err_state_reg[pi] <= ERR_TRIP;
                           2'h1:    err_state_reg[pi] <= ERR_HOLD;
                           2'h2:    err_state_reg[pi] <= ERR_HOLD;
                           default: err_state_reg[pi] <= ERR_IDLE;
                        endcase
                     end
                  end
                  ERR_HOLD:
                  begin
                     if (cfg_arr[pi].error_action == 2'h2 && link_recovered[pi])
                     begin
                        err_state_reg[pi] <= ERR_IDLE;
                     end
                     else if (tenth_cnt_reg[pi] >= cfg_arr[pi].error_timer ||
                              tenth_cnt_reg[pi] >= `TIMER_MAX_TENTHS)
                     begin
                        err_state_reg[pi] <= ERR_TRIP;
                     end
                     else if (tick_cnt_reg[pi] == TW'(TENTH_TICKS - 1))
                     begin
                        tick_cnt_reg[pi]  <= '0;
                        tenth_cnt_reg[pi] <= tenth_cnt_reg[pi] + 1'b1;
                     end
                     else
                     begin
                        tick_cnt_reg[pi] <= tick_cnt_reg[pi] + 1'b1;
                     end
                  end
                  ERR_TRIP:
                  begin
                     err_state_reg[pi] <= ERR_TRIP;
                  end
                  default:
                  begin
                     err_state_reg[pi] <= ERR_IDLE;
                  end
               endcase
            end
         end

         assign trip[pi] = (err_state_reg[pi] == ERR_TRIP);
      end
   endgenerate

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         display_reg <= 2'h0;
         alarm_reg   <= 1'b0;
      end
      else if (ce)
      begin
         display_reg <= trip;
         alarm_reg   <= |trip;
      end
   end

   assign link_valid            = le_level || (|override_reg);
   assign support_link_override = override_reg;
   assign freq_from_link        = freq_link;
   assign run_from_link         = run_link;
   assign applied_cmd           = applied_reg;
   assign port1_frame           = frame_reg[0];
   assign port2_frame           = frame_reg[1];
   assign error_display         = display_reg;
   assign alarm_stop            = alarm_reg;
endmodule

// [sim/link_ctrl_asserts.sv]
`timescale 1ns/1ps
`include "link_cfg.svh"
module link_ctrl_asserts #(
   parameter int NUM_TERM = 7
) (
   input wire logic                   clk,
   input wire logic                   srst,
   input wire logic                   ce,
   input wire logic [NUM_TERM-1:0]    terminal_level,
   input wire logic [NUM_TERM*11-1:0] input_terminal_function_codes,
   input wire logic [1:0]             support_link_override_wr_data,
   input wire logic                   support_link_override_wr,
   input wire logic                   cmd_valid,
   input wire logic                   cmd_ready,
   input wire link_pkg::port_cfg_t    port1_cfg,
   input wire link_pkg::port_cfg_t    port2_cfg,
   input wire logic [1:0]             char_boundary,
   input wire link_pkg::link_err_t    port1_err,
   input wire logic                   running,
   input wire logic                   link_valid,
   input wire logic [1:0]             support_link_override,
   input wire logic                   freq_from_link,
   input wire logic                   run_from_link,
   input wire link_pkg::frame_cfg_t   port1_frame,
   input wire logic [1:0]             respond_enable,
   input wire logic [1:0]             error_display,
   input wire logic                   alarm_stop
);
   logic       le_any;
   logic       le_on;
   logic [7:0] frm1;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   function automatic logic addr_ok(link_pkg::port_cfg_t c);
      case (c.protocol)
         link_pkg::PROTO_RTU:     return c.station_address <= `RTU_ADDR_MAX;
         link_pkg::PROTO_LOADER:  return c.station_address != 8'h00;
         link_pkg::PROTO_GENERAL: return c.station_address == `GEN_BROADCAST ||
                                         (c.station_address != 8'h00 && c.station_address <= `GEN_ADDR_MAX);
         default:                 return 1'b0;
      endcase
   endfunction
   function automatic logic [7:0] frm(link_pkg::port_cfg_t c);
      logic [1:0] s;
      if (c.protocol == link_pkg::PROTO_RTU)
         s = (c.parity_code == 2'h0) ? 2'h2 : 2'h1;
      else
         s = c.stop_bits ? 2'h1 : 2'h2;
      return {c.char_length ? 4'h7 : 4'h8, (c.parity_code == 2'h3) ? 2'h0 : c.parity_code, s};
   endfunction
   always_comb
   begin
      le_any = 1'b0;
      le_on  = 1'b0;
      for (int i = 0; i < NUM_TERM; i++)
      begin
         if (input_terminal_function_codes[i*11 +: 11] inside {`LE_FUNC_CODE, `LE_FUNC_CODE_NEG})
         begin
            le_any = 1'b1;
            le_on  = le_on | (terminal_level[i] ^ input_terminal_function_codes[i*11+10]);
         end
      end
   end
   assign frm1 = frm(port1_cfg);
   property p_ovr_reset;
      $fell(srst) |-> support_link_override == 2'h0;
   endproperty
   a_ovr_reset: assert property (p_ovr_reset) else $error("override not cleared by reset");
   property p_ovr_wr;
      ce && support_link_override_wr |=> support_link_override == $past(support_link_override_wr_data);
   endproperty
   a_ovr_wr: assert property (p_ovr_wr) else $error("override write lost");
   property p_ovr_hold;
      !(ce && support_link_override_wr) |=> $stable(support_link_override);
   endproperty
   a_ovr_hold: assert property (p_ovr_hold) else $error("override changed without write");
   property p_link_valid;
      support_link_override == 2'h0 |-> link_valid == (!le_any || le_on);
   endproperty
   a_link_valid: assert property (p_link_valid) else $error("link valid wrong");
   property p_force;
      (support_link_override & ~{run_from_link, freq_from_link}) == 2'h0;
   endproperty
   a_force: assert property (p_force) else $error("override did not force source");
   property p_respond;
      respond_enable == {addr_ok(port2_cfg), addr_ok(port1_cfg)};
   endproperty
   a_respond: assert property (p_respond) else $error("respond enable wrong");
   property p_frame_hold;
      !(ce && char_boundary[0]) |=> $stable(port1_frame);
   endproperty
   a_frame_hold: assert property (p_frame_hold) else $error("frame changed mid character");
   property p_frame_load;
      ce && char_boundary[0] && port1_cfg.protocol != link_pkg::PROTO_LOADER |=>
         {port1_frame.data_bits, port1_frame.parity, port1_frame.stop_count} == $past(frm1);
   endproperty
   a_frame_load: assert property (p_frame_load) else $error("frame decode wrong");
   property p_alarm_sticky;
      alarm_stop |=> alarm_stop;
   endproperty
   a_alarm_sticky: assert property (p_alarm_sticky) else $error("alarm stop released");
   property p_act0;
      ce && running && freq_from_link && run_from_link && (|port1_err) && port1_cfg.error_action == 2'h0
         && !alarm_stop |-> ##[1:3] (alarm_stop && error_display[0]);
   endproperty
   a_act0: assert property (p_act0) else $error("immediate stop missing");
   c_full: cover property (ce && cmd_valid && !cmd_ready);
   c_trip: cover property ($rose(alarm_stop));
   c_ovr: cover property (ce && support_link_override_wr);
endmodule
bind link_ctrl link_ctrl_asserts #(.NUM_TERM(NUM_TERM)) u_link_ctrl_asserts (.*);

// [sim/host_model.sv]
`timescale 1ns/1ps
module host_model (
   input  wire logic                clk,
   input  wire logic                srst,
   input  wire logic                ce,
   input  wire logic                cmd_ready,
   output      logic                cmd_valid,
   output      link_pkg::link_cmd_t cmd_data
);
   link_pkg::link_cmd_t q[$];
   int                  accepted = 0;
   int                  gap = 0;
   int                  idle = 0;
   initial
   begin
      cmd_valid = 1'b0;
      cmd_data  = '0;
      forever
      begin
         @(posedge clk);
         if (cmd_valid && cmd_ready && ce)
         begin
            accepted++;
            void'(q.pop_front());
            idle = gap;
         end
         if (q.size() != 0 && idle == 0 && !srst)
         begin
            cmd_valid <= 1'b1;
            cmd_data  <= q[0];
         end
         else
         begin
            if (idle > 0)
               idle--;
            cmd_valid <= 1'b0;
            cmd_data  <= ~cmd_data;
         end
      end
   end
endmodule

// [sim/tb_link_ctrl.sv]
`timescale 1ns/1ps
module tb_link_ctrl;
   logic clk, srst, ce, ovr_wr, cmd_valid, cmd_ready, running, link_valid, freq_from_link, run_from_link, alarm_stop;
   logic [6:0]           terminal_level;
   logic [76:0]          input_terminal_function_codes;
   logic [3:0]           link_source_select;
   logic [1:0]           ovr_data, char_boundary, link_recovered, support_link_override, respond_enable, error_display;
   link_pkg::link_cmd_t  cmd_data, applied_cmd, last_cmd, seen_q[$];
   link_pkg::port_cfg_t  p1, p2;
   link_pkg::link_err_t  e1, e2;
   link_pkg::frame_cfg_t f1, f2;
   int                   num_errors, comparisons, cycles, bd[6];
   logic [10:0]          lec[5] = '{11'h000, 11'h018, 11'h018, 11'h418, 11'h418};
   logic [1:0]           pa[9] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h3};
   logic [7:0]           ad[9] = '{8'h00, 8'hF7, 8'hF8, 8'h00, 8'hFF, 8'h1F, 8'h20, 8'h63, 8'h01};
   logic [5:0]           cf[6] = '{6'h00, 6'h0C, 6'h01, 6'h27, 6'h2A, 6'h1C};
   logic [7:0]           fe[6] = '{8'h82, 8'h79, 8'h82, 8'h81, 8'h76, 8'h84};
   logic [8:0]           xv[4] = '{9'h015, 9'h1EC, 9'h1BA, 9'h0B3};
   host_model u_host_model (.*);
   link_ctrl #(.TENTH_TICKS(10)) u_link_ctrl (.support_link_override_wr_data(ovr_data),
      .support_link_override_wr(ovr_wr), .port1_cfg(p1), .port2_cfg(p2), .port1_err(e1), .port2_err(e2),
      .port1_frame(f1), .port2_frame(f2), .*);
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic do_reset();
      @(posedge clk);
      srst <= 1'b1;
      cyc(6);
      srst <= 1'b0;
   endtask
   task automatic set_le(input int t, input logic [10:0] code, input logic lvl);
      input_terminal_function_codes <= {66'h0, code} << (t * 11);
      terminal_level <= {6'h0, lvl} << t;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         num_errors++;
         end_of_test();
      end
      if (!srst && applied_cmd !== last_cmd)
      begin
         seen_q.push_back(applied_cmd);
         last_cmd = applied_cmd;
      end
   end
   initial
   begin
      {srst, ce, ovr_wr, ovr_data, running, char_boundary, link_recovered} = 10'h300;
      terminal_level = 7'h00;
      input_terminal_function_codes = 77'h0;
      link_source_select = 4'h3;
      p1 = '0;
      p1.error_action = 2'h3;
      p2 = p1;
      p2.protocol = link_pkg::PROTO_GENERAL;
      p2.station_address = 8'h63;
      e1 = '0;
      e2 = '0;
      last_cmd = '0;
      {num_errors, comparisons, cycles} = '0;
      do_reset();
      cyc(1);
      #1 chk("reset", {support_link_override, applied_cmd, alarm_stop, error_display}, 64'h0);
      chk("frame", {f1.data_bits, f1.parity, f1.stop_count}, fe[0]);
      for (int i = 0; i < 5; i++)
      begin
         cyc(1);
         set_le(3, lec[i], (5'h0D >> i) & 1);
         cyc(1);
         #1 chk("valid", {link_valid, freq_from_link, run_from_link}, {3{xv[0][i]}});
      end
      for (int c = 0; c < 9; c++)
      begin
         cyc(1);
         link_source_select <= 4'(c);
         cyc(1);
         #1 chk("source", {run_from_link, freq_from_link}, {xv[1][c], xv[2][c]});
      end
      cyc(1);
      set_le(2, 11'h018, 1'b0);
      link_source_select <= 4'h3;
      u_host_model.gap = 1;
      for (int i = 0; i < 9; i++)
         u_host_model.q.push_back(48'h1111_2222_0000 + 48'(i));
      cyc(30);
      #1 chk("held", {cmd_ready, applied_cmd}, 64'h0);
      chk("taken", u_host_model.accepted, 64'h8);
      seen_q.delete();
      cyc(1);
      terminal_level <= 7'h04;
      cyc(40);
      #1 chk("count", seen_q.size(), 64'h9);
      foreach (seen_q[i])
         chk("order", seen_q[i], 48'h1111_2222_0000 + 48'(i));
      cyc(1);
      terminal_level <= 7'h00;
      link_source_select <= 4'h0;
      ce <= 1'b0;
      ovr_wr <= 1'b1;
      ovr_data <= 2'h3;
      cyc(1);
      ce <= 1'b1;
      ovr_wr <= 1'b0;
      cyc(1);
      #1 chk("frozen", support_link_override, 64'h0);
      for (int v = 1; v < 4; v++)
      begin
         cyc(1);
         ovr_wr <= 1'b1;
         ovr_data <= 2'(v);
         cyc(1);
         ovr_wr <= 1'b0;
         cyc(1);
         #1 chk("override", {support_link_override, run_from_link, freq_from_link}, {2'(v), 2'(v)});
      end
      do_reset();
      cyc(1);
      #1 chk("cleared", {support_link_override, applied_cmd}, 64'h0);
      for (int i = 0; i < 9; i++)
      begin
         cyc(1);
         p1.protocol <= link_pkg::proto_t'(pa[i]);
         p1.station_address <= ad[i];
         cyc(1);
         #1 chk("respond", respond_enable, {1'b1, xv[3][i]});
      end
      for (int i = 1; i < 6; i++)
      begin
         cyc(1);
         char_boundary <= 2'h0;
         p1.protocol <= link_pkg::proto_t'(cf[i][5:4]);
         {p1.char_length, p1.parity_code, p1.stop_bits} <= cf[i][3:0];
         cyc(3);
         #1 chk("hold", {f1.data_bits, f1.parity, f1.stop_count}, fe[i-1]);
         cyc(1);
         char_boundary <= 2'h1;
         cyc(2);
         #1 chk("frame", {f1.data_bits, f1.parity, (i == 5) ? 2'h0 : f1.stop_count}, fe[i]);
      end
      chk("port2", {f2.data_bits, f2.parity, f2.stop_count}, fe[0]);
      for (int c = 0; c < 6; c++)
      begin
         cyc(1);
         p1.baud_code <= 3'(c);
         cyc(2);
         #1 bd[c] = f1.baud_div;
      end
      for (int c = 1; c < 6; c++)
         chk("baud", bd[c] > 0 && ((c == 5) ? bd[5] == bd[4] : (bd[c-1] + 2 >= 2 * bd[c] && bd[c-1] <= 2 * bd[c] + 2)),
            64'h1);
      cyc(1);
      set_le(0, 11'h000, 1'b0);
      p1.error_action <= 2'h0;
      e1 <= 5'h02;
      cyc(10);
      #1 chk("stopped", alarm_stop, 64'h0);
      cyc(1);
      running <= 1'b1;
      link_source_select <= 4'h1;
      cyc(10);
      #1 chk("one_src", alarm_stop, 64'h0);
      cyc(1);
      e1 <= '0;
      link_source_select <= 4'h3;
      p1.error_action <= 2'h3;
      p1.error_timer <= 10'h002;
      cyc(1);
      e1 <= 5'h04;
      cyc(30);
      #1 chk("act3", {alarm_stop, error_display}, 64'h0);
      cyc(1);
      e1 <= '0;
      p1.error_action <= 2'h2;
      cyc(1);
      e1 <= 5'h08;
      cyc(5);
      e1 <= '0;
      link_recovered <= 2'h1;
      cyc(30);
      #1 chk("act2", {alarm_stop, error_display}, 64'h0);
      cyc(1);
      link_recovered <= 2'h0;
      p1.error_action <= 2'h1;
      cyc(1);
      e1 <= 5'h10;
      cyc(12);
      #1 chk("act1_wait", {alarm_stop, error_display}, 64'h0);
      cyc(20);
      #1 chk("act1_trip", {alarm_stop, error_display}, 64'h5);
      p1.error_action <= 2'h0;
      p2.error_action <= 2'h0;
      for (int j = 0; j < 5; j++)
      begin
         do_reset();
         e1 <= (j % 2 == 0) ? 5'h01 << j : 5'h00;
         e2 <= (j % 2 == 1) ? 5'h01 << j : 5'h00;
         cyc(4);
         #1 chk("trip", {alarm_stop, error_display}, {1'b1, 2'h1 << (j % 2)});
      end
      end_of_test();
   end
endmodule
